// [pkg/usart_cg_pkg.sv]
package usart_cg_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL_STATUS_A  = 3'h0; // double speed, frame error, rx data valid
  localparam logic [2:0] ADDR_CTRL_STATUS_B  = 3'h1; // enables, ninth tx bit, char size bit 2
  localparam logic [2:0] ADDR_CTRL_STATUS_C  = 3'h2; // sync select, parity, stop, size, polarity
  localparam logic [2:0] ADDR_BAUD_DIV_LOW   = 3'h3; // divisor bits 7:0, reloads counter
  localparam logic [2:0] ADDR_BAUD_DIV_HIGH  = 3'h4; // divisor bits 11:8
  localparam logic [2:0] ADDR_DATA           = 3'h5; // write starts tx, read gives rx
  localparam logic [2:0] ADDR_RX_NINTH       = 3'h6; // received ninth bit and parity error
  // ctrl_status_a fields
  localparam int A_DOUBLE_SPEED = 1;
  localparam int A_FRAME_ERROR  = 4;
  localparam int A_RX_VALID     = 7;
  localparam int A_TX_BUSY      = 5;
  // ctrl_status_b fields
  localparam int B_TX_NINTH     = 0;
  localparam int B_SIZE2        = 2;
  localparam int B_TX_ENABLE    = 3;
  localparam int B_RX_ENABLE    = 4;
  localparam int B_XCK_OUTPUT   = 5;
  // ctrl_status_c fields
  localparam int C_POLARITY     = 0;
  localparam int C_SIZE_LO      = 1;
  localparam int C_STOP2        = 3;
  localparam int C_PARITY_LO    = 4;
  localparam int C_SYNC_MODE    = 6;
  // reset values
  localparam logic [7:0] RESET_A = 8'h00;
  localparam logic [7:0] RESET_B = 8'h00;
  localparam logic [7:0] RESET_C = 8'h06;
  // divisor and sample counts
  localparam int DIV_WIDTH      = 12;
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] SAMPLES_SYNC   = 5'h02;
  // parity mode encodings and the nine-bit char size code
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD  = 2'h3;
  localparam logic [2:0] SIZE_NINE   = 3'h7;
  // frame states
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2} frame_state_e;
  // data bits for a char size code
  function automatic logic [3:0] dataBits(input logic [2:0] size);
    if (size == SIZE_NINE)
      return 4'h9;
    else if (size > 3'h3)
      return 4'h8;
    else
      return 4'(size) + 4'h5;
  endfunction
  // parity of a 9-bit character limited to its width
  function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (4'(i) < n)
        p = p ^ d[i];
    return p;
  endfunction
endpackage

// [pkg/usart_tick_if.sv]
`timescale 1ns/10ps
`default_nettype none
// ticks handed from clock generation to the serial engine
interface usart_tick_if;
  logic baudTick; // one per divisor expiry
  logic syncMode; // synchronous selected
  logic master;   // synchronous master
  logic txEdge;   // data change edge in slave mode
  logic rxEdge;   // data sample edge in slave mode
  modport gen  (output baudTick, txEdge, rxEdge, input syncMode, master);
  modport user (input baudTick, txEdge, rxEdge, output syncMode, master);
endinterface
`default_nettype wire

// [rtl/usart_baud_gen.sv]
`timescale 1ns/10ps
`default_nettype none
// baud down-counter plus external clock synchroniser and edge detect
module usart_baud_gen
  import usart_cg_pkg::*;
#(
  parameter int WIDTH = usart_cg_pkg::DIV_WIDTH
)(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // configuration
  input  wire logic [WIDTH-1:0]  divisor,
  input  wire logic              reloadNow,
  input  wire logic              polarity,
  // external transfer clock pin level
  input  wire logic              extClockIn,
  // tick carrier
  usart_tick_if.gen              ticks
);
  logic [WIDTH-1:0] count;      // down-counter
  logic [WIDTH-1:0] next_count;
  logic             syncA;      // first synchroniser stage
  logic             syncB;      // second stage
  logic             syncC;      // previous for edge detect
  logic             next_tick;
  logic             next_txEdge;
  logic             next_rxEdge;

  // counter reload and tick
  always_comb
  begin
    next_tick = 1'b0;
    if (reloadNow)
      next_count = divisor;
    else if (count == '0)
    begin
      next_count = divisor;
      next_tick = 1'b1;
    end
    else
      next_count = count - 1'b1;
    // edge detect after synchroniser
    next_txEdge = 1'b0;
    next_rxEdge = 1'b0;
    if (ticks.syncMode && !ticks.master)
    begin
      next_txEdge = polarity ? (syncC & ~syncB) : (~syncC & syncB);
      next_rxEdge = polarity ? (~syncC & syncB) : (syncC & ~syncB);
    end
  end

  // registers
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      count <= '0;
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
      ticks.baudTick <= 1'b0;
      ticks.txEdge <= 1'b0;
      ticks.rxEdge <= 1'b0;
    end
    else
    begin
      count <= next_count;
      syncA <= extClockIn;
      syncB <= syncA;
      syncC <= syncB;
      ticks.baudTick <= next_tick;
      ticks.txEdge <= next_txEdge;
      ticks.rxEdge <= next_rxEdge;
    end
  end

  a_tick_at_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (count == '0 && !reloadNow) |=> ticks.baudTick)
    else $error("no tick after zero");
  a_reload_low: assert property (@(posedge clock) disable iff (!rst_b)
    reloadNow |=> (count == $past(divisor)))
    else $error("low write did not reload");
endmodule
`default_nettype wire

// [rtl/usart_frame_fmt.sv]
`timescale 1ns/10ps
`default_nettype none
// holds shared frame format and mode settings
module usart_frame_fmt
  import usart_cg_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // register writes
  input  wire logic       wrB,
  input  wire logic       wrC,
  input  wire logic [7:0] wrData,
  // settings
  output logic [7:0]      regB,
  output logic [7:0]      regC
);
  logic [7:0] next_regB; // control b
  logic [7:0] next_regC; // control c

  // write decode
  always_comb
  begin
    next_regB = wrB ? wrData : regB;
    next_regC = wrC ? wrData : regC;
  end

  // register
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      regB <= RESET_B;
      regC <= RESET_C;
    end
    else
    begin
      regB <= next_regB;
      regC <= next_regC;
    end
  end
endmodule
`default_nettype wire

// [rtl/usart_clock_frame.sv]
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module usart_clock_frame
  import usart_cg_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic [7:0]      rdData,
  // serial pins
  output logic            serialTxPin,
  input  wire logic       serialRxPin,
  // transfer clock pin, enable low while driving
  input  wire logic       transferClockIn,
  output logic            transferClockOut,
  output logic            transferClockOe_n
);
  usart_tick_if ticks ();
  logic [7:0]  regA;          // status a stored bits
  logic [7:0]  regB;          // control b
  logic [7:0]  regC;          // control c
  logic [11:0] baudDivisor;   // twelve-bit divisor
  logic [11:0] next_baudDivisor;
  logic [1:0]  rxSyncPin;     // rx pin synchroniser
  logic [2:0]  charSize;
  logic [3:0]  nBits;
  logic [1:0]  parityMode;
  logic        syncMode;
  logic        master;
  logic [4:0]  samples;
  logic        txEnable;
  logic        rxEnable;
  logic        bitTick;       // transmit bit step
  logic        sampleTick;    // receive sub-sample
  // transmitter state
  frame_state_e txState, next_txState;
  logic [4:0]  txDiv, next_txDiv;
  logic [8:0]  txShift, next_txShift;
  logic [3:0]  txCount, next_txCount;
  logic        txOut, next_txOut;
  logic        txParity, next_txParity;
  logic [8:0]  txHold, next_txHold;
  logic        txPending, next_txPending;
  logic        xckOut, next_xckOut;
  // receiver state
  frame_state_e rxState, next_rxState;
  logic [4:0]  rxDiv, next_rxDiv;
  logic [8:0]  rxShift, next_rxShift;
  logic [3:0]  rxCount, next_rxCount;
  logic [8:0]  rxData, next_rxData;
  logic        rxValid, next_rxValid;
  logic        frameErr, next_frameErr;
  logic        parErr, next_parErr;
  logic        rxBit;
  logic        rxStep;
  logic [7:0]  next_rdData;
  logic [7:0]  next_regA;

  // settings decode, shared by both directions
  assign charSize   = {regB[B_SIZE2], regC[C_SIZE_LO+1:C_SIZE_LO]};
  assign nBits      = dataBits(charSize);
  assign parityMode = regC[C_PARITY_LO+1:C_PARITY_LO];
  assign syncMode   = regC[C_SYNC_MODE];
  assign master     = regB[B_XCK_OUTPUT];
  assign txEnable   = regB[B_TX_ENABLE];
  assign rxEnable   = regB[B_RX_ENABLE];
  assign ticks.syncMode = syncMode;
  assign ticks.master   = master;
  assign rxBit      = rxSyncPin[1];

  // recovery length: async 16 or 8, sync master 2
  always_comb
  begin
    if (syncMode)
      samples = SAMPLES_SYNC;
    else if (regA[A_DOUBLE_SPEED])
      samples = SAMPLES_DOUBLE;
    else
      samples = SAMPLES_NORMAL;
  end

  // slave edges replace ticks
  always_comb
  begin
    if (syncMode && !master)
    begin
      bitTick = ticks.txEdge;
      sampleTick = ticks.rxEdge;
    end
    else
    begin
      bitTick = ticks.baudTick && (txDiv == samples - 5'h01);
      sampleTick = ticks.baudTick;
    end
  end

  usart_baud_gen #(.WIDTH(DIV_WIDTH)) baudGen (
    .clock      (clock),
    .rst_b      (rst_b),
    .divisor    (next_baudDivisor),
    .reloadNow  (wrStrobe && addr == ADDR_BAUD_DIV_LOW),
    .polarity   (regC[C_POLARITY]),
    .extClockIn (transferClockIn),
    .ticks      (ticks)
  );

  usart_frame_fmt fmt (
    .clock  (clock),
    .rst_b  (rst_b),
    .wrB    (wrStrobe && addr == ADDR_CTRL_STATUS_B),
    .wrC    (wrStrobe && addr == ADDR_CTRL_STATUS_C),
    .wrData (wrData),
    .regB   (regB),
    .regC   (regC)
  );

  // register writes, divisor and read mux
  always_comb
  begin
    next_baudDivisor = baudDivisor;
    next_regA = regA;
    if (wrStrobe && addr == ADDR_BAUD_DIV_LOW)
      next_baudDivisor[7:0] = wrData;
    if (wrStrobe && addr == ADDR_BAUD_DIV_HIGH)
      next_baudDivisor[11:8] = wrData[3:0];
    if (wrStrobe && addr == ADDR_CTRL_STATUS_A)
      next_regA[A_DOUBLE_SPEED] = wrData[A_DOUBLE_SPEED];
    next_rdData = 8'h00;
    if (rdStrobe)
      case (addr)
        ADDR_CTRL_STATUS_A: next_rdData = {rxValid, 1'b0, txPending || txState != ST_IDLE, frameErr,
                                           2'b00, regA[A_DOUBLE_SPEED], 1'b0};
        ADDR_CTRL_STATUS_B: next_rdData = regB;
        ADDR_CTRL_STATUS_C: next_rdData = regC;
        ADDR_BAUD_DIV_LOW:  next_rdData = baudDivisor[7:0];
        ADDR_BAUD_DIV_HIGH: next_rdData = {4'h0, baudDivisor[11:8]};
        ADDR_DATA:          next_rdData = rxData[7:0];
        ADDR_RX_NINTH:      next_rdData = {6'h00, parErr, rxData[8]};
        default:            next_rdData = 8'h00;
      endcase
  end

  // transmitter next state
  always_comb
  begin
    next_txState = txState;
    next_txDiv = txDiv;
    next_txShift = txShift;
    next_txCount = txCount;
    next_txOut = txOut;
    next_txParity = txParity;
    next_txHold = txHold;
    next_txPending = txPending;
    next_xckOut = xckOut;
    if (wrStrobe && addr == ADDR_DATA)
    begin
      next_txHold = {regB[B_TX_NINTH], wrData};
      next_txPending = 1'b1;
    end
    // master clock toggles on each baud tick, idle at polarity level
    if (syncMode && master && ticks.baudTick)
      next_xckOut = ~xckOut;
    else if (!(syncMode && master))
      next_xckOut = regC[C_POLARITY];
    if (ticks.baudTick && !(syncMode && !master))
      next_txDiv = (txDiv == samples - 5'h01) ? 5'h00 : txDiv + 5'h01;
    if (bitTick)
      case (txState)
        ST_IDLE:
          if (txPending && txEnable)
          begin
            next_txShift = txHold;
            next_txParity = parityOf(txHold, nBits, parityMode == PARITY_ODD);
            next_txPending = 1'b0;
            next_txOut = 1'b0;
            next_txCount = 4'h0;
            next_txState = ST_START;
          end
          else
            next_txOut = 1'b1;
        ST_START, ST_DATA:
          begin
            next_txOut = txShift[0];
            next_txShift = {1'b0, txShift[8:1]};
            next_txCount = txCount + 4'h1;
            next_txState = (txCount + 4'h1 == nBits) ? ((parityMode == PARITY_NONE) ? ST_STOP1 : ST_PARITY) : ST_DATA;
          end
        ST_PARITY:
          begin
            next_txOut = txParity;
            next_txState = ST_STOP1;
          end
        ST_STOP1:
          begin
            next_txOut = 1'b1;
            next_txState = regC[C_STOP2] ? ST_STOP2 : ST_IDLE;
          end
        ST_STOP2:
          begin
            next_txOut = 1'b1;
            next_txState = ST_IDLE;
          end
        default: next_txState = ST_IDLE;
      endcase
    if (txState == ST_DATA && bitTick && txCount == nBits)
      next_txState = ST_IDLE;
  end

  // receiver next state, mid-bit sampling
  always_comb
  begin
    next_rxState = rxState;
    next_rxDiv = rxDiv;
    next_rxShift = rxShift;
    next_rxCount = rxCount;
    next_rxData = rxData;
    next_rxValid = rxValid;
    next_frameErr = frameErr;
    next_parErr = parErr;
    rxStep = 1'b0;
    if (rdStrobe && addr == ADDR_DATA)
      next_rxValid = 1'b0;
    if (sampleTick)
    begin
      if (syncMode)
        rxStep = 1'b1;
      else
      begin
        next_rxDiv = rxDiv + 5'h01;
        rxStep = (rxDiv == (samples >> 1) - 5'h01);
        if (rxDiv == samples - 5'h01)
          next_rxDiv = 5'h00;
      end
    end
    if (rxState == ST_IDLE)
    begin
      next_rxDiv = 5'h00;
      if (sampleTick && rxEnable && !rxBit)
      begin
        next_rxState = ST_START;
        next_rxDiv = syncMode ? 5'h00 : 5'h01;
        next_rxCount = 4'h0;
        if (syncMode)
          next_rxState = ST_DATA;
      end
    end
    else if (rxStep)
      case (rxState)
        ST_START: next_rxState = rxBit ? ST_IDLE : ST_DATA;
        ST_DATA:
          begin
            next_rxShift = {rxBit, rxShift[8:1]};
            next_rxCount = rxCount + 4'h1;
            if (rxCount + 4'h1 == nBits)
              next_rxState = (parityMode == PARITY_NONE) ? ST_STOP1 : ST_PARITY;
          end
        ST_PARITY:
          begin
            next_parErr = rxBit != parityOf(rxShift >> (4'h9 - nBits), nBits, parityMode == PARITY_ODD);
            next_rxState = ST_STOP1;
          end
        ST_STOP1:
          begin
            next_frameErr = !rxBit;
            next_rxData = rxShift >> (4'h9 - nBits);
            next_rxValid = 1'b1;
            next_rxState = ST_IDLE;
          end
        default: next_rxState = ST_IDLE;
      endcase
  end

  // all registers
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      regA <= RESET_A;
      baudDivisor <= '0;
      rdData <= 8'h00;
      rxSyncPin <= 2'b11;
      txState <= ST_IDLE;
      txDiv <= 5'h00;
      txShift <= 9'h000;
      txCount <= 4'h0;
      txOut <= 1'b1;
      txParity <= 1'b0;
      txHold <= 9'h000;
      txPending <= 1'b0;
      xckOut <= 1'b0;
      rxState <= ST_IDLE;
      rxDiv <= 5'h00;
      rxShift <= 9'h000;
      rxCount <= 4'h0;
      rxData <= 9'h000;
      rxValid <= 1'b0;
      frameErr <= 1'b0;
      parErr <= 1'b0;
      serialTxPin <= 1'b1;
      transferClockOut <= 1'b0;
      transferClockOe_n <= 1'b1;
    end
    else
    begin
      regA <= next_regA;
      baudDivisor <= next_baudDivisor;
      rdData <= next_rdData;
      rxSyncPin <= {rxSyncPin[0], serialRxPin};
      txState <= next_txState;
      txDiv <= next_txDiv;
      txShift <= next_txShift;
      txCount <= next_txCount;
      txOut <= next_txOut;
      txParity <= next_txParity;
      txHold <= next_txHold;
      txPending <= next_txPending;
      xckOut <= next_xckOut;
      rxState <= next_rxState;
      rxDiv <= next_rxDiv;
      rxShift <= next_rxShift;
      rxCount <= next_rxCount;
      rxData <= next_rxData;
      rxValid <= next_rxValid;
      frameErr <= next_frameErr;
      parErr <= next_parErr;
      serialTxPin <= txEnable ? next_txOut : 1'b1;
      transferClockOut <= next_xckOut;
      transferClockOe_n <= !(syncMode && master);
    end
  end

  a_pin_idle_async: assert property (@(posedge clock) disable iff (!rst_b)
    !syncMode |=> transferClockOe_n)
    else $error("clock pin driven in async mode");
  a_start_low: assert property (@(posedge clock) disable iff (!rst_b)
    (txState == ST_START) |-> !txOut)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge clock) disable iff (!rst_b)
    (txState == ST_STOP2 || txState == ST_IDLE) |-> txOut)
    else $error("stop bit not high");
  a_div_normal: assert property (@(posedge clock) disable iff (!rst_b)
    (!syncMode && !regA[A_DOUBLE_SPEED]) |-> samples == 5'h10)
    else $error("normal divide wrong");
  a_div_double: assert property (@(posedge clock) disable iff (!rst_b)
    (!syncMode && regA[A_DOUBLE_SPEED]) |-> samples == 5'h08)
    else $error("double divide wrong");
  a_div_sync: assert property (@(posedge clock) disable iff (!rst_b)
    syncMode |-> samples == 5'h02)
    else $error("sync divide wrong");
  a_slave_edges: assert property (@(posedge clock) disable iff (!rst_b)
    (syncMode && !master) |-> (bitTick == ticks.txEdge))
    else $error("slave shift not from edge");
  a_nine_bits: assert property (@(posedge clock) disable iff (!rst_b)
    (charSize == SIZE_NINE) |-> nBits == 4'h9)
    else $error("size seven not nine bits");
  c_frame_sent: cover property (@(posedge clock) disable iff (!rst_b)
    txState == ST_STOP1 ##1 txState == ST_IDLE);
  c_frame_rx: cover property (@(posedge clock) disable iff (!rst_b)
    $rose(rxValid));
  c_frame_err: cover property (@(posedge clock) disable iff (!rst_b)
    $rose(frameErr));
endmodule
`default_nettype wire

// [verification/usart_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
// far-end serial station: decodes our tx line and sends frames back
module usart_far_model (
  // clock
  input  wire logic        clock,
  // frame shape
  input  wire logic [15:0] bitClks,
  input  wire logic [3:0]  nSlots,
  // serial lines
  input  wire logic        txLine,
  output logic             rxLine,
  // decoded frame, first bit at 0, ones past the end
  output logic             fValid,
  output logic [12:0]      fWord
);
  logic [12:0] w; // bits gathered so far
  // listener: start on a falling line, sample mid bit
  initial
  begin
    rxLine = 1'b1; // idle line high
    fValid = 1'b0;
    fWord  = 13'h1fff;
    forever
    begin
      @(negedge txLine); // frame opens with the low start bit
      w = 13'h1fff; // past the frame the line idles high
      repeat (bitClks / 2) @(posedge clock);
      for (int i = 0; i < nSlots; i++)
      begin
        w[i] = txLine; // one sample per bit, first bit at 0
        repeat (bitClks) @(posedge clock);
      end
      fWord <= w;
      fValid <= 1'b1;
      @(posedge clock);
      fValid <= 1'b0;
    end
  end
  // speaker: one bit per bitClks, bit 0 first, then idle high
  task automatic sendFrame(input logic [12:0] s, input logic [3:0] n);
    for (int i = 0; i < n; i++)
    begin
      rxLine <= s[i];
      repeat (bitClks) @(posedge clock);
    end
    rxLine <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [verification/usart_clock_frame_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// bench: registers, all frame formats both ways, master clock
module usart_clock_frame_tb;
  import usart_cg_pkg::*;
  logic        clock = 1'b0;       // system clock
  logic        rst_b = 1'b0;       // sync reset
  logic [2:0]  addr = 3'h0;        // register index
  logic [7:0]  wrData = 8'h00;     // write data
  logic        wrStrobe = 1'b0;    // write pulse
  logic        rdStrobe = 1'b0;    // read pulse
  logic        rdSeen = 1'b0;      // read answer due
  logic [7:0]  rdData;             // read answer
  logic        txPin;              // serial out
  logic        rxPin;              // serial in
  logic        xckOut;             // master clock
  logic        xckOe_n;            // clock pin enable
  logic        xckIn = 1'b0;       // slave clock pin level
  logic [15:0] bitClks = 16'h0020; // clocks per bit
  logic [3:0]  nSlots = 4'h1;      // bits per frame
  logic        fValid;             // far frame done
  logic [12:0] fWord;              // far frame bits
  logic [7:0]  rdQ[$];             // expected reads
  logic [12:0] frQ[$];             // expected frames
  int          mismatches = 0;     // mismatch count
  int          checksDone = 0;     // compare count
  int          cycles = 0;         // timeout counter
  int          n;                  // clock high count
  always #4 clock = ~clock;
  usart_clock_frame dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .serialTxPin(txPin), .serialRxPin(rxPin),
    .transferClockIn(xckIn), .transferClockOut(xckOut), .transferClockOe_n(xckOe_n));
  usart_far_model far (.clock(clock), .bitClks(bitClks), .nSlots(nSlots), .txLine(txPin),
    .rxLine(rxPin), .fValid(fValid), .fWord(fWord));
  // compare and count
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle register write, then a quiet cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    @(posedge clock);
  endtask
  // one-cycle register read, answer noted for the watcher
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    @(posedge clock);
  endtask
  // one format: send a random character, get it back looped
  task automatic txrx(input logic [1:0] pm, input logic [2:0] sz, input logic st, input logic bad);
    logic [3:0]  nb; // data bits
    logic        pe; // parity on
    logic [8:0]  d;  // character
    logic [12:0] s;  // frame bits, first sent at 0
    nb = (sz == SIZE_NINE) ? 4'h9 : 4'(sz) + 4'h5;
    pe = pm[1];
    d = 9'($urandom) & ~(9'h1ff << nb);
    s = (13'(d) << 1) | (13'h1fff << (nb + 1 + pe));
    s[nb + 1] = pe ? (^d) ^ pm[0] : s[nb + 1];
    nSlots <= nb + 2 + pe + st;
    wr(ADDR_CTRL_STATUS_C, {2'h0, pm, st, sz[1:0], 1'b0});
    wr(ADDR_CTRL_STATUS_B, {3'h0, 2'h3, sz[2], 1'b0, d[8]});
    frQ.push_back(s);
    wr(ADDR_DATA, d[7:0]);
    for (int i = 0; i < 600 && fValid !== 1'b1; i++)
      @(posedge clock);
    if (bad)
    begin
      s[nb + 1] = ~s[nb + 1]; // wrong parity
      s[nb + 2] = 1'b0;       // first stop low
    end
    far.sendFrame(s, nb + 2 + pe + st);
    repeat (bitClks) @(posedge clock);
    rd(ADDR_CTRL_STATUS_A, {1'b1, 2'h0, bad, 2'h0, bitClks == 16'h0010, 1'b0});
    rd(ADDR_RX_NINTH, {6'h0, bad, d[8]});
    rd(ADDR_DATA, d[7:0]);
  endtask
  // watcher: oldest note against what appears, plus timeout
  always @(posedge clock)
  begin
    if (rdSeen)
      check(13'(rdData), 13'(rdQ.pop_front()));
    if (fValid === 1'b1)
      check(fWord, frQ.pop_front());
    rdSeen <= rdStrobe;
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(43638));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    check(13'(xckOe_n), 13'h0001);
    rd(ADDR_CTRL_STATUS_A, RESET_A);
    rd(ADDR_CTRL_STATUS_B, RESET_B);
    rd(ADDR_CTRL_STATUS_C, RESET_C);
    rd(3'h7, 8'h00);
    wr(ADDR_BAUD_DIV_HIGH, 8'h0f);
    rd(ADDR_BAUD_DIV_HIGH, 8'h0f);
    wr(ADDR_BAUD_DIV_HIGH, 8'h00);
    wr(ADDR_BAUD_DIV_LOW, 8'h01);
    rd(ADDR_BAUD_DIV_LOW, 8'h01);
    // all 30 formats at 16 samples per bit, last one also faulty
    for (int k = 0; k < 30; k++)
      txrx(k < 10 ? PARITY_NONE : 2'(k / 10 + 1), (k / 2) % 5 == 4 ? SIZE_NINE : 3'((k / 2) % 5), k % 2 == 1,
        k == 29);
    // double speed, 8 samples per bit
    wr(ADDR_CTRL_STATUS_A, 8'h02);
    bitClks <= 16'h0010;
    txrx(PARITY_EVEN, 3'h3, 1'b0, 1'b0);
    // synchronous master: pin driven, toggles each tick
    wr(ADDR_CTRL_STATUS_A, 8'h00);
    wr(ADDR_CTRL_STATUS_C, 8'h46);
    wr(ADDR_CTRL_STATUS_B, 8'h28);
    repeat (4) @(posedge clock);
    check(13'(xckOe_n), 13'h0000);
    @(posedge xckOut);
    n = 0;
    @(negedge clock);
    while (xckOut === 1'b1)
    begin
      n++;
      @(negedge clock);
    end
    check(13'(n), 13'h0002);
    // synchronous slave: a rising pin edge steps the transmitter
    wr(ADDR_CTRL_STATUS_B, 8'h08);
    wr(ADDR_DATA, 8'h00);
    repeat (8) @(posedge clock);
    check(13'(txPin), 13'h0001);
    xckIn <= 1'b1; // single slow edge, far under a quarter rate
    repeat (6) @(posedge clock);
    check(13'(txPin), 13'h0000);
    repeat (4) @(posedge clock);
    check(13'(rdQ.size() + frQ.size()), 13'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
